// [hw/psc_pkg.sv]
// Purpose: Constants for the phantom serial clock access front end.
// Assumes: One 125 MHz clock, synchronous active-low reset.
// Notes: Contract
// Contract
// - Access needs 64 matching key writes.
// - Before key, pass chip select through.
// - After key, 64 data cycles, memory disabled.
// - Read starts sequence, pointer to bit zero.
// - Matching key bit advances pointer.
// - Mismatch stalls pointer, later writes ignored.
// - Read during recognition aborts, resets pointer.
// - Data cycle captures or drives one bit.
// - Cycles without chip select change nothing.
// - Power fail forces memory select high.
// - Normal supply: memory select follows input.
// - Power fail aborts transfer, refuses access.
// - Below switchover: ignore inputs, float outputs.
// - Key C5 3A A3 5C twice, LSB first.
// - Transfer walks bit 0 reg 0 upward.
// - Abort input honoured unless ignore bit set.
package psc_pkg;
   localparam int           KEY_BITS   = 64;
   localparam int           DATA_BITS  = 64;
   localparam logic [63:0]  KEY_VALUE  = 64'h5CA33AC55CA33AC5;
   localparam int           PTR_W      = 6;
   localparam logic [5:0]   PTR_RESET  = 6'h00;
   localparam logic [5:0]   PTR_LAST   = 6'h3F;
   localparam logic [63:0]  REGS_RESET = 64'h0000000000000000;
   // Reset-ignore control bit: bit 4 of register 5 (day register).
   localparam int           IGNORE_POS = 44;
   typedef enum logic [2:0]
   {
      PSC_IDLE  = 3'b001,
      PSC_MATCH = 3'b010,
      PSC_XFER  = 3'b100
   } psc_state_e;
endpackage

// [hw/phantom_serial_clock_access.sv]
// Purpose: Key recognition and serial data transfer front end.
// Assumes: Pins sampled by core_clk; a bus cycle ends on chip select rising.
// Notes: Power conditions arrive as comparator levels from the analogue side.
`timescale 1ns/100ps
`default_nettype none
module psc_phantom_serial_clock_access
(
   // Clock and reset.
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // Host bus pins.
   input  wire logic                  chip_select_in_n,
   input  wire logic                  write_enable_n,
   input  wire logic                  output_enable_n,
   input  wire logic                  serial_data_in,
   input  wire logic                  transfer_abort_n,
   // Supply monitor levels, high while supply is below the level.
   input  wire logic                  below_power_fail_threshold,
   input  wire logic                  below_battery_switchover_level,
   // Memory and serial output pins.
   output var  logic                  memory_select_passthrough_n,
   output var  logic                  serial_data_out,
   output var  logic                  serial_data_out_en,
   // Timekeeping register image.
   output var  logic [psc_pkg::DATA_BITS-1:0] clock_regs
);
   import psc_pkg::*;

   typedef struct packed
   {
      logic [1:0]  csS;
      logic [1:0]  weS;
      logic [1:0]  oeS;
      logic [1:0]  dS;
      logic [1:0]  rstS;
      logic [1:0]  pfS;
      logic [1:0]  soS;
      logic        inCycle;
      logic        cycWrite;
      logic        cycBit;
      psc_state_e  state;
      logic [5:0]  ptr;
      logic        miss;
      logic [63:0] regs;
      logic        passN;
      logic        qOut;
      logic        qEn;
   } psc_s;

   psc_s cur;
   psc_s next_cur;

   logic csN;
   logic weN;
   logic oeN;
   logic dIn;
   logic abortN;
   logic pFail;
   logic sOver;
   logic cycEnd;
   logic blocked;
   logic selBit;
   logic abortHit;

   // Pointer helpers shared by the state logic and the checks.
   function automatic logic ptrIsLast(input logic [5:0] p);
      ptrIsLast = (p == PTR_LAST);
   endfunction

   function automatic logic [5:0] ptrStep(input logic [5:0] p);
      ptrStep = p + 6'h01;
   endfunction

   // One pointer walks both the key and the register image, so the lengths must agree.
   if (KEY_BITS != DATA_BITS || KEY_BITS != (1 << PTR_W) || PTR_W != 6)
   begin : gLengthCheck
      $error("Key, data and pointer widths do not agree.");
   end

   always_comb
   begin
      next_cur = cur;
      csN      = cur.csS[1];
      weN      = cur.weS[1];
      oeN      = cur.oeS[1];
      dIn      = cur.dS[1];
      abortN   = cur.rstS[1];
      pFail    = cur.pfS[1];
      sOver    = cur.soS[1];
      blocked  = pFail | sOver;
      selBit   = cur.regs[cur.ptr];
      abortHit = (cur.state == PSC_XFER) & !abortN & !cur.regs[IGNORE_POS];
      next_cur.csS  = {cur.csS[0], chip_select_in_n};
      next_cur.weS  = {cur.weS[0], write_enable_n};
      next_cur.oeS  = {cur.oeS[0], output_enable_n};
      next_cur.dS   = {cur.dS[0], serial_data_in};
      next_cur.rstS = {cur.rstS[0], transfer_abort_n};
      next_cur.pfS  = {cur.pfS[0], below_power_fail_threshold};
      next_cur.soS  = {cur.soS[0], below_battery_switchover_level};
      cycEnd = cur.inCycle & csN;
      // Track the cycle type; a cycle is taken when chip select rises.
      if (!csN && !blocked)
      begin
         next_cur.inCycle = 1'b1;
         if (!weN)
         begin
            next_cur.cycWrite = 1'b1;
            next_cur.cycBit   = dIn;
         end
         else if (!cur.inCycle)
         begin
            next_cur.cycWrite = 1'b0;
         end
      end
      else
      begin
         next_cur.inCycle = 1'b0;
      end
      if (blocked)
      begin
         next_cur.state = PSC_IDLE;
         next_cur.ptr   = PTR_RESET;
         next_cur.miss  = 1'b0;
      end
      else if (abortHit)
      begin
         next_cur.state = PSC_IDLE;
         next_cur.ptr   = PTR_RESET;
      end
      else if (cycEnd)
      begin
         case (cur.state)
            PSC_IDLE:
            begin
               if (!cur.cycWrite)
               begin
                  next_cur.state = PSC_MATCH;
                  next_cur.ptr   = PTR_RESET;
                  next_cur.miss  = 1'b0;
               end
            end
            PSC_MATCH:
            begin
               if (!cur.cycWrite)
               begin
                  next_cur.ptr  = PTR_RESET;
                  next_cur.miss = 1'b0;
               end
               else if (!cur.miss && cur.cycBit == KEY_VALUE[cur.ptr])
               begin
                  next_cur.ptr = ptrStep(cur.ptr);
                  if (ptrIsLast(cur.ptr))
                  begin
                     next_cur.state = PSC_XFER;
                  end
               end
               else
               begin
                  next_cur.miss = 1'b1;
               end
            end
            PSC_XFER:
            begin
               if (cur.cycWrite)
               begin
                  next_cur.regs[cur.ptr] = cur.cycBit;
               end
               next_cur.ptr = ptrStep(cur.ptr);
               if (ptrIsLast(cur.ptr))
               begin
                  next_cur.state = PSC_IDLE;
               end
            end
            default:
            begin
               next_cur.state = PSC_IDLE;
            end
         endcase
      end
      // Memory select: forced high on fail or while transferring.
      if (blocked)
      begin
         next_cur.passN = 1'b1;
      end
      else if (cur.state == PSC_XFER)
      begin
         next_cur.passN = 1'b1;
      end
      else
      begin
         next_cur.passN = csN;
      end
      next_cur.qOut = selBit;
      next_cur.qEn  = (cur.state == PSC_XFER) & !blocked & !csN & weN & !oeN;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         cur       <= '0;
         cur.csS   <= 2'h3;
         cur.weS   <= 2'h3;
         cur.oeS   <= 2'h3;
         cur.rstS  <= 2'h3;
         cur.state <= PSC_IDLE;
         cur.ptr   <= PTR_RESET;
         cur.regs  <= REGS_RESET;
         cur.passN <= 1'b1;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign memory_select_passthrough_n = cur.passN;
   assign serial_data_out             = cur.qOut;
   assign serial_data_out_en          = cur.qEn;
   assign clock_regs                  = cur.regs;

   sequence seqFail;
      cur.pfS[1] | cur.soS[1];
   endsequence

   chk_fail_forces_select: assert property (@(posedge core_clk) disable iff (!rst_n)
      seqFail |=> memory_select_passthrough_n)
      else $error("Memory select low during power fail.");
   chk_xfer_blocks_mem: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cur.state == PSC_XFER) |=> memory_select_passthrough_n)
      else $error("Memory enabled during transfer.");
   chk_idle_follows_cs: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cur.state != PSC_XFER && !blocked) |=> memory_select_passthrough_n == $past(cur.csS[1]))
      else $error("Memory select does not follow chip select.");
   chk_fail_aborts_seq: assert property (@(posedge core_clk) disable iff (!rst_n)
      seqFail |=> cur.state == PSC_IDLE && $stable(cur.regs))
      else $error("Transfer not aborted on power fail.");
   chk_out_float_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      !cur.weS[1] |=> !serial_data_out_en)
      else $error("Output driven in write cycle.");
   chk_out_float_oe: assert property (@(posedge core_clk) disable iff (!rst_n)
      cur.oeS[1] |=> !serial_data_out_en)
      else $error("Output driven without output enable.");
   chk_deselect_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cur.csS[1] && !cur.inCycle && cur.rstS[1] && !blocked)
      |=> $stable(cur.state) && $stable(cur.ptr))
      else $error("State changed without chip select.");
   chk_read_resets_ptr: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cur.state == PSC_MATCH && cycEnd && !cur.cycWrite && !blocked)
      |=> cur.ptr == PTR_RESET && !cur.miss)
      else $error("Read did not reset pointer.");
   chk_miss_stalls_ptr: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cur.state == PSC_MATCH && cur.miss && cycEnd && cur.cycWrite && !blocked)
      |=> $stable(cur.ptr))
      else $error("Pointer moved after mismatch.");
   chk_xfer_end_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cur.state == PSC_XFER && cycEnd && ptrIsLast(cur.ptr)) |=> cur.state == PSC_IDLE)
      else $error("No return to recognition after transfer.");

   // Key walk: a matching bit moves the pointer, the last one opens the transfer.
   sequence seqKeyHit;
      cur.state == PSC_MATCH && cycEnd && cur.cycWrite && !cur.miss && !blocked
      && cur.cycBit == KEY_VALUE[cur.ptr];
   endsequence

   sequence seqKeyMiss;
      cur.state == PSC_MATCH && cycEnd && cur.cycWrite && !cur.miss && !blocked
      && cur.cycBit != KEY_VALUE[cur.ptr];
   endsequence

   // Data walk: a finished write stores its bit, a live read drives the pin.
   sequence seqXferWrite;
      cur.state == PSC_XFER && cycEnd && cur.cycWrite && !blocked && !abortHit;
   endsequence

   sequence seqXferRead;
      cur.state == PSC_XFER && !blocked && !cur.csS[1] && cur.weS[1] && !cur.oeS[1];
   endsequence

   chk_key_bit_advance: assert property (@(posedge core_clk) disable iff (!rst_n)
      seqKeyHit |=> cur.ptr == ptrStep($past(cur.ptr)))
      else $error("Pointer did not advance on a matching key bit.");
   chk_key_grant: assert property (@(posedge core_clk) disable iff (!rst_n)
      seqKeyHit ##0 ptrIsLast(cur.ptr)
      |=> cur.state == PSC_XFER ##1 memory_select_passthrough_n)
      else $error("Full key match did not open the transfer.");
   chk_key_bit_miss: assert property (@(posedge core_clk) disable iff (!rst_n)
      seqKeyMiss |=> cur.miss && $stable(cur.ptr))
      else $error("Key mismatch did not stall the pointer.");
   chk_read_starts_seq: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cur.state == PSC_IDLE && cycEnd && !cur.cycWrite && !blocked)
      |=> cur.state == PSC_MATCH && cur.ptr == PTR_RESET)
      else $error("Opening read did not start recognition.");
   chk_write_stores_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
      seqXferWrite |=> cur.regs[$past(cur.ptr)] == $past(cur.cycBit))
      else $error("Data write did not land at the pointer.");
   chk_read_drives_out: assert property (@(posedge core_clk) disable iff (!rst_n)
      seqXferRead |=> serial_data_out_en && serial_data_out == $past(selBit))
      else $error("Data read did not drive the addressed bit.");
   chk_abort_pin_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      (abortHit && !blocked) |=> cur.state == PSC_IDLE && $stable(cur.regs))
      else $error("Abort input did not end the transfer cleanly.");
   chk_switch_floats_out: assert property (@(posedge core_clk) disable iff (!rst_n)
      cur.soS[1] |=> !serial_data_out_en)
      else $error("Output driven below switchover.");
   chk_deselect_float: assert property (@(posedge core_clk) disable iff (!rst_n)
      cur.csS[1] |=> !serial_data_out_en)
      else $error("Output driven while deselected.");
endmodule
`default_nettype wire

// [bench/psc_host_model.sv]
// Purpose: Host bus model that runs key, data and read cycles.
// Assumes: Pins change on the falling edge of core_clk.
// Notes: Data pin shows the inverse of its last value between cycles.
`timescale 1ns/100ps
`default_nettype none
module psc_host_model
(
   // Clock.
   input  wire logic core_clk,
   // Bus pins.
   output var  logic csN,
   output var  logic weN,
   output var  logic oeN,
   output var  logic sdi
);
   initial
   begin
      csN = 1'b1;
      weN = 1'b1;
      oeN = 1'b1;
      sdi = 1'b0;
   end
   // Opens a cycle; a read uses output enable.
   // Chip select left off gives a cycle aimed at other memory on the bus.
   task automatic start(input logic cs, input logic wr, input logic oe, input logic d);
      @(negedge core_clk);
      csN = ~cs;
      weN = ~wr;
      oeN = ~oe;
      sdi = d;
   endtask
   // Closes a cycle and keeps chip select high for four clocks.
   task automatic stop();
      csN = 1'b1;
      weN = 1'b1;
      oeN = 1'b1;
      sdi = ~sdi;
      repeat (4) @(negedge core_clk);
   endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the phantom access front end.
// Assumes: Reset held ten clocks; bus cycles of four clocks low and five high.
// Notes: Pass-through and serial output are sampled late in each cycle.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import psc_pkg::*;
   logic        coreClk = 1'b0;
   logic        rstN = 1'b0;
   logic        abortN = 1'b1;
   logic        pFail = 1'b0;
   logic        bSwitch = 1'b0;
   logic        csN, weN, oeN, sdi, ptN, sdo, sdoEn;
   logic [63:0] regs;
   logic [63:0] pat = 64'h0123456789ABCDEF;
   int          errTotal = 0;
   int          checksDone = 0;
   int          cycles = 0;
   always #4 coreClk = ~coreClk;
   psc_host_model u_host (.core_clk(coreClk), .csN(csN), .weN(weN), .oeN(oeN), .sdi(sdi));
   psc_phantom_serial_clock_access u_dut
   (
      .core_clk(coreClk), .rst_n(rstN), .chip_select_in_n(csN), .write_enable_n(weN),
      .output_enable_n(oeN), .serial_data_in(sdi), .transfer_abort_n(abortN),
      .below_power_fail_threshold(pFail), .below_battery_switchover_level(bSwitch),
      .memory_select_passthrough_n(ptN), .serial_data_out(sdo),
      .serial_data_out_en(sdoEn), .clock_regs(regs)
   );
   task automatic finalReport();
      $display("checks %0d mismatches %0d", checksDone, errTotal);
      if (errTotal == 0 && checksDone > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         errTotal++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input logic wr, input logic d, output logic pt, output logic q);
      cycMix(1'b1, wr, ~wr, d, pt, q);
   endtask
   task automatic cycMix(input logic cs, input logic wr, input logic oe, input logic d,
                         output logic pt, output logic q);
      u_host.start(cs, wr, oe, d);
      repeat (4) @(negedge coreClk);
      pt = ptN;
      q = sdoEn ? sdo : 1'bz;
      u_host.stop();
   endtask
   task automatic key(input logic [63:0] k);
      logic pt, q;
      cyc(1'b0, 1'b0, pt, q);
      for (int i = 0; i < 64; i++)
         cyc(1'b1, k[i], pt, q);
      check("key pass", {63'h0, pt}, 64'h0);
      check("key out", {63'h0, q}, {63'h0, 1'bz});
   endtask
   task automatic sWriteRead();
      logic pt, q;
      logic [63:0] r;
      key(KEY_VALUE);
      for (int i = 0; i < 64; i++)
         cyc(1'b1, pat[i], pt, q);
      check("xfer pass", {63'h0, pt}, 64'h1);
      check("regs", regs, pat);
      key(KEY_VALUE);
      for (int i = 0; i < 64; i++)
      begin
         cyc(1'b0, 1'b0, pt, q);
         r[i] = q;
      end
      check("read data", r, pat);
      cyc(1'b1, 1'b0, pt, q);
      check("after xfer", {63'h0, pt}, 64'h0);
   endtask
   task automatic sRefused();
      logic pt, q;
      key(KEY_VALUE ^ 64'h400);
      cyc(1'b1, 1'b1, pt, q);
      check("mismatch", {63'h0, pt}, 64'h0);
      key(64'h0);
      cyc(1'b1, 1'b1, pt, q);
      check("zero key", {63'h0, pt}, 64'h0);
      cyc(1'b0, 1'b0, pt, q);
      for (int i = 0; i < 20; i++)
         cyc(1'b1, KEY_VALUE[i], pt, q);
      cyc(1'b0, 1'b0, pt, q);
      for (int i = 20; i < 64; i++)
         cyc(1'b1, KEY_VALUE[i], pt, q);
      cyc(1'b1, 1'b1, pt, q);
      check("read abort", {63'h0, pt}, 64'h0);
      check("regs kept", regs, pat);
   endtask
   task automatic sPower();
      logic pt, q;
      key(KEY_VALUE);
      cyc(1'b1, 1'b1, pt, q);
      pFail = 1'b1;
      cyc(1'b1, 1'b1, pt, q);
      check("fail pass", {63'h0, pt}, 64'h1);
      pFail = 1'b0;
      cyc(1'b1, 1'b1, pt, q);
      check("fail abort", {63'h0, pt}, 64'h0);
      bSwitch = 1'b1;
      cyc(1'b0, 1'b0, pt, q);
      check("switch out", {63'h0, q}, {63'h0, 1'bz});
      bSwitch = 1'b0;
      key(KEY_VALUE);
      cyc(1'b1, 1'b1, pt, q);
      cycMix(1'b0, 1'b1, 1'b0, 1'b0, pt, q);
      cycMix(1'b0, 1'b0, 1'b1, 1'b0, pt, q);
      check("foreign out", {63'h0, q}, {63'h0, 1'bz});
      cycMix(1'b1, 1'b1, 1'b1, ~pat[1], pt, q);
      check("write oe out", {63'h0, q}, {63'h0, 1'bz});
      cycMix(1'b1, 1'b0, 1'b0, 1'b0, pt, q);
      check("read oe out", {63'h0, q}, {63'h0, 1'bz});
      check("oe write", regs, pat ^ 64'h2);
      abortN = 1'b0;
      repeat (4) @(negedge coreClk);
      abortN = 1'b1;
      cyc(1'b1, 1'b1, pt, q);
      check("abort pin", {63'h0, pt}, 64'h0);
      check("regs kept", regs, pat ^ 64'h2);
      check("deselect", {63'h0, sdoEn}, 64'h0);
   endtask
   always @(posedge coreClk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errTotal++;
         finalReport();
      end
   end
   initial
   begin
      repeat (10) @(negedge coreClk);
      rstN = 1'b1;
      sWriteRead();
      sRefused();
      sPower();
      finalReport();
   end
endmodule
`default_nettype wire
